/* pcg_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_monitor
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire pcg_pkg::pcg_bus_req_t bus_req,
  input wire logic [pcg_pkg::DATA_W-1:0] rdata,
  input wire logic [pcg_pkg::CRYSTAL_SELECTION_W-1:0] crystal_selection,
  input wire logic auto_clock_gating,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_access,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_gclk,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_bus_fault,
  input wire logic [pcg_pkg::RATE_W-1:0] converter_max_sample_rate,
  input wire logic [pcg_pkg::PLL_OD_W-1:0] pll_output_divider_field,
  input wire logic [pcg_pkg::PLL_F_W-1:0] pll_feedback,
  input wire logic [pcg_pkg::PLL_R_W-1:0] pll_ref_divider
);
  import pcg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [15:0] pll_now;
  assign pll_now = {pll_output_divider_field, pll_feedback, pll_ref_divider};
  sequence s_run_wr(a);
    bus_req.wr && bus_req.addr == a && !auto_clock_gating;
  endsequence
  sequence s_quiet;
    (!bus_req.wr && !auto_clock_gating) [*2];
  endsequence
  property p_fault;
    unit_bus_fault == $past(unit_access & ~unit_clk_en);
  endproperty
  property p_reset;
    $rose(resetn) |-> unit_clk_en == '0 && converter_max_sample_rate == '0;
  endproperty
  property p_pll_rd;
    $past(resetn) && $stable(crystal_selection) && bus_req.rd && bus_req.addr == OFS_PLL_TRANSLATION
      |=> rdata == {16'h0000, pll_now};
  endproperty
  property p_pll_hold;
    $past(resetn) && $stable(crystal_selection) |=> $stable(pll_now);
  endproperty
  property p_g0;
    s_run_wr(OFS_RUN_GATE0) |-> ##2 {unit_clk_en[U_WDT:U_PWM], converter_max_sample_rate}
      == $past({bus_req.wdata[3], bus_req.wdata[16], bus_req.wdata[20],
      ((bus_req.wdata[11:8] > RATE_250K) ? RATE_250K : bus_req.wdata[11:8])}, 2);
  endproperty
  property p_g1;
    s_run_wr(OFS_RUN_GATE1) |-> ##2 unit_clk_en[U_SECOND_ASYNC_SERIAL_GATE:U_COMPARATOR_ZERO_GATE]
      == $past({bus_req.wdata[1:0], bus_req.wdata[4], bus_req.wdata[18:16], bus_req.wdata[24]}, 2);
  endproperty
  property p_quiet;
    s_quiet |-> ##2 $stable(unit_clk_en);
  endproperty
  property p_gclk;
    @(negedge clk) unit_gclk == $past(unit_clk_en);
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag wrong");
  a_reset: assert property (p_reset) else $error("gate not clear after reset");
  a_pll_rd: assert property (p_pll_rd) else $error("translation readback wrong");
  a_pll_hold: assert property (p_pll_hold) else $error("translation moved");
  a_g0: assert property (p_g0) else $error("group 0 enables wrong");
  a_g1: assert property (p_g1) else $error("group 1 enables wrong");
  a_quiet: assert property (p_quiet) else $error("enables moved while idle");
  a_gclk: assert property (p_gclk) else $error("gated clock high phase wrong");
endmodule // pcg_monitor

bind pcg_top pcg_monitor u_mon (.clk, .resetn, .bus_req, .rdata, .crystal_selection, .auto_clock_gating,
  .unit_access, .unit_clk_en, .unit_gclk, .unit_bus_fault, .converter_max_sample_rate,
  .pll_output_divider_field, .pll_feedback, .pll_ref_divider);
`default_nettype wire

/* pcg_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_partner
  import pcg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic legal,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en,
  output logic [pcg_pkg::NUM_UNITS-1:0] unit_access
);
  import pcg_pkg::*;
  int seed = 32'h9c95;
  // Peripheral accesses from the bus fabric
  always @(posedge clk or negedge resetn)
    if (!resetn)
      unit_access <= '0;
    else if (legal)
      unit_access <= NUM_UNITS'($random(seed)) & unit_clk_en;
    else
      unit_access <= NUM_UNITS'($random(seed));
endmodule // pcg_partner
`default_nettype wire

/* pcg_pkg.sv */
package pcg_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_UNITS = 15;
  localparam int NUM_MODES = 3;
  localparam int NUM_GROUPS = 3;

  // Register offsets
  localparam logic [11:0] OFS_PLL_TRANSLATION = 12'h064;
  localparam logic [11:0] OFS_RUN_GATE0 = 12'h100;
  localparam logic [11:0] OFS_RUN_GATE1 = 12'h104;
  localparam logic [11:0] OFS_RUN_GATE2 = 12'h108;
  localparam logic [11:0] OFS_SLEEP_GATE0 = 12'h110;
  localparam logic [11:0] OFS_SLEEP_GATE1 = 12'h114;
  localparam logic [11:0] OFS_SLEEP_GATE2 = 12'h118;
  localparam logic [11:0] OFS_DEEP_GATE0 = 12'h120;
  localparam logic [11:0] OFS_DEEP_GATE1 = 12'h124;
  localparam logic [11:0] OFS_DEEP_GATE2 = 12'h128;

  // Writable bits of each gating group; all others are reserved
  localparam logic [31:0] GROUP0_MASK = 32'h0011_0f08;
  localparam logic [31:0] GROUP1_MASK = 32'h0107_0013;
  localparam logic [31:0] GROUP2_MASK = 32'h0000_001f;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  // Group 0 fields
  localparam int G0_PWM_BIT = 20;
  localparam int G0_ADC_BIT = 16;
  localparam int G0_RATE_LSB = 8;
  localparam int G0_WDT_BIT = 3;
  localparam int RATE_W = 4;
  localparam logic [3:0] RATE_125K = 4'h0;
  localparam logic [3:0] RATE_250K = 4'h1;

  // Group 1 fields
  localparam int G1_COMPARATOR_ZERO_GATE_BIT = 24;
  localparam int G1_TIMER2_BIT = 18;
  localparam int G1_TIMER1_BIT = 17;
  localparam int G1_TIMER0_BIT = 16;
  localparam int G1_SSI_BIT = 4;
  localparam int G1_SECOND_ASYNC_SERIAL_GATE_BIT = 1;
  localparam int G1_FIRST_ASYNC_SERIAL_GATE_BIT = 0;

  // Group 2 fields: GPIO ports A..E in bits 0..4
  localparam int G2_GPIO_LSB = 0;
  localparam int GPIO_PORTS = 5;

  // Unit indices on the gate vectors
  localparam int U_PWM = 0;
  localparam int U_ADC = 1;
  localparam int U_WDT = 2;
  localparam int U_COMPARATOR_ZERO_GATE = 3;
  localparam int U_TIMER0 = 4;
  localparam int U_TIMER1 = 5;
  localparam int U_TIMER2 = 6;
  localparam int U_SSI = 7;
  localparam int U_FIRST_ASYNC_SERIAL_GATE = 8;
  localparam int U_SECOND_ASYNC_SERIAL_GATE = 9;
  localparam int U_GPIO_A = 10;

  // PLL translation fields
  localparam int PLL_OD_LSB = 14;
  localparam int PLL_OD_W = 2;
  localparam int PLL_F_LSB = 5;
  localparam int PLL_F_W = 9;
  localparam int PLL_R_LSB = 0;
  localparam int PLL_R_W = 5;
  localparam int PLL_W = 16;
  localparam int CRYSTAL_SELECTION_W = 4;
  localparam logic [15:0] PLL_RESET = 16'h0000;
  localparam logic [3:0] CRYSTAL_SELECTION_RESET = 4'h0;

  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pcg_bus_req_t;

  typedef struct packed {
    logic [31:0] group2;
    logic [31:0] group1;
    logic [31:0] group0;
  } pcg_gate_set_t;

endpackage

/* pcg_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module pcg_tb_top;
  import pcg_pkg::*;
  // Translation table, values arbitrary
  localparam logic [255:0] TAB = 256'h0123_4567_89ab_cdef_fedc_ba98_7654_3210_1357_9bdf_2468_ace0_0f1e_2d3c_4b5a_6978;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  pcg_bus_req_t bus_req = '0;
  logic [3:0] crystal_selection = 4'hb;
  logic [2:0] pmode = 3'h0;
  logic legal = 1'b1;
  logic [31:0] rdata;
  logic [14:0] unit_access, unit_clk_en, unit_gclk, unit_bus_fault;
  logic [3:0] rate;
  logic [31:0] g [9];
  logic [31:0] mask [3] = '{GROUP0_MASK, GROUP1_MASK, GROUP2_MASK};
  int num_errors = 0;
  int cmp_count = 0;
  int seed = 32'h9c95;
  int cyc = 0;

  pcg_top #(.PLL_TABLE(TAB)) DUT (.clk, .resetn, .bus_req, .rdata, .crystal_selection,
    .auto_clock_gating(pmode[2]), .sleep_state(pmode[1]), .deep_sleep_state(pmode[0]),
    .unit_access, .unit_clk_en, .unit_gclk, .unit_bus_fault, .converter_max_sample_rate(rate),
    .pll_output_divider_field(), .pll_feedback(), .pll_ref_divider());
  pcg_partner u_far (.clk, .resetn, .legal, .unit_clk_en, .unit_access);

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  function automatic logic [11:0] gate_addr(input int k);
    return OFS_RUN_GATE0 + 12'((k / 3) * 16 + (k % 3) * 4);
  endfunction

  // Rate and unit enables of the active set
  function automatic logic [31:0] exp_en(input logic [2:0] pm);
    int m;
    logic [31:0] a, b, c;
    logic [3:0] r;
    m = (pm[2] && pm[0]) ? 2 : (pm[2] && pm[1]) ? 1 : 0;
    a = g[m * 3];
    b = g[m * 3 + 1];
    c = g[m * 3 + 2];
    r = (a[11:8] > RATE_250K) ? RATE_250K : a[11:8];
    return {13'h0, r, c[4:0], b[1:0], b[4], b[18:16], b[24], a[3], a[16], a[20]};
  endfunction

  function automatic logic [31:0] exp_pll(input logic [3:0] x);
    return {16'h0, TAB[{x, 4'h0} +: 16]};
  endfunction

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      complete_run;
    end
  end

  initial
  begin
    int i;
    int k;
    logic [31:0] d;
    logic [14:0] acc;
    logic [31:0] en;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (k = 0; k < 9; k++)
      rd_chk(gate_addr(k), 32'h0);
    rd_chk(OFS_PLL_TRANSLATION, exp_pll(crystal_selection));
    for (i = 0; i < 36; i++)
    begin
      k = i % 9;
      d = (i < 9) ? 32'hffff_ffff : $random(seed);
      bus_wr(gate_addr(k), d);
      g[k] = d & mask[k % 3];
      rd_chk(gate_addr(k), g[k]);
      bus_wr(OFS_PLL_TRANSLATION, d);
      bus_wr(12'h200, d);
      rd_chk(12'h200, 32'h0);
      rd_chk(OFS_PLL_TRANSLATION, exp_pll(crystal_selection));
    end
    for (i = 0; i < 24; i++)
    begin
      @(posedge clk);
      pmode <= i[2:0];
      crystal_selection <= 4'($random(seed));
      repeat (4) @(posedge clk);
      #1;
      chk({13'h0, rate, unit_clk_en}, exp_en(i[2:0]));
      chk(32'(unit_gclk), 32'(unit_clk_en));
      chk(32'(unit_bus_fault), 32'h0);
      rd_chk(OFS_PLL_TRANSLATION, exp_pll(crystal_selection));
    end
    legal <= 1'b0;
    en = exp_en(pmode);
    @(posedge clk);
    #1;
    acc = unit_access;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      chk(32'(unit_bus_fault), 32'(acc & ~en[14:0]));
      acc = unit_access;
    end
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(32'(unit_clk_en), 32'h0);
    for (k = 0; k < 9; k++)
      rd_chk(gate_addr(k), 32'h0);
    rd_chk(OFS_PLL_TRANSLATION, exp_pll(crystal_selection));
    complete_run;
  end
endmodule // pcg_tb_top
`default_nettype wire

/* pcg_top.sv */
// Functional notes
// - Load PLL translation after reset and whenever crystal selection changes.
// - PLL translation bits 15:14 show the output divider driven to the PLL.
// - PLL translation bits 13:5 show the feedback multiplier driven to the PLL.
// - PLL translation bits 4:0 show the reference divider; bits 31:16 reserved.
// - Each gating bit outside group 0 bits 11:8 enables one peripheral clock; zero stops it.
// - Access to a peripheral whose clock is gated off raises a bus fault.
// - All gating bits reset to zero, every peripheral starts unclocked.
// - Sleep and deep-sleep sets apply only while auto clock gating is set.
// - Group 0: bit 20 PWM, bit 16 ADC, bit 3 watchdog; rest reserved except 11:8.
// - Group 0 bits 11:8 select the maximum converter sample rate.
// - Group 1: bit 24 comparator 0, bits 18..16 timers 2..0.
// - Group 1: bit 4 sync serial, bits 1 and 0 the UARTs; rest reserved.
// - Reserved bits are preserved by software; here they read zero.
// - Group 0 copies sit at 0x100, 0x110 and 0x120.
// - Group 1 copies sit at 0x104, 0x114 and 0x124.
// - Group 2 run and sleep copies sit at 0x108 and 0x118.
// - Group 2 deep copy sits at 0x128; bits 4..0 gate GPIO E..A.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module pcg_top
  import pcg_pkg::*;
#(
  parameter logic [255:0] PLL_TABLE = 256'h0
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire pcg_pkg::pcg_bus_req_t bus_req,
  output logic [pcg_pkg::DATA_W-1:0] rdata,
  input wire logic [pcg_pkg::CRYSTAL_SELECTION_W-1:0] crystal_selection,
  input wire logic auto_clock_gating,
  input wire logic sleep_state,
  input wire logic deep_sleep_state,
  input wire logic [pcg_pkg::NUM_UNITS-1:0] unit_access,
  output logic [pcg_pkg::NUM_UNITS-1:0] unit_clk_en,
  output logic [pcg_pkg::NUM_UNITS-1:0] unit_gclk,
  output logic [pcg_pkg::NUM_UNITS-1:0] unit_bus_fault,
  output logic [pcg_pkg::RATE_W-1:0] converter_max_sample_rate,
  output logic [pcg_pkg::PLL_OD_W-1:0] pll_output_divider_field,
  output logic [pcg_pkg::PLL_F_W-1:0] pll_feedback,
  output logic [pcg_pkg::PLL_R_W-1:0] pll_ref_divider
);
  import pcg_pkg::*;

  // Offset of one gating register copy
  function automatic logic [ADDR_W-1:0] gate_offset(input int mode, input int grp);
    logic [ADDR_W-1:0] ofs;
    ofs = OFS_RUN_GATE0;
    case (mode * NUM_GROUPS + grp)
      0: ofs = OFS_RUN_GATE0;
      1: ofs = OFS_RUN_GATE1;
      2: ofs = OFS_RUN_GATE2;
      3: ofs = OFS_SLEEP_GATE0;
      4: ofs = OFS_SLEEP_GATE1;
      5: ofs = OFS_SLEEP_GATE2;
      6: ofs = OFS_DEEP_GATE0;
      7: ofs = OFS_DEEP_GATE1;
      8: ofs = OFS_DEEP_GATE2;
      default: ofs = OFS_RUN_GATE0;
    endcase
    return ofs;
  endfunction

  // Writable mask of a gating group
  function automatic logic [31:0] group_mask(input int grp);
    logic [31:0] m;
    m = GROUP0_MASK;
    case (grp)
      0: m = GROUP0_MASK;
      1: m = GROUP1_MASK;
      2: m = GROUP2_MASK;
      default: m = GROUP0_MASK;
    endcase
    return m;
  endfunction

  // Fastest converter rate the part supports
  localparam logic [RATE_W-1:0] RATE_MAX = RATE_250K;

  // Converter rate clipped to the supported range
  function automatic logic [RATE_W-1:0] limit_rate(input logic [RATE_W-1:0] req);
    logic [RATE_W-1:0] r;
    r = req;
    if (req > RATE_MAX)
    begin
      r = RATE_MAX;
    end
    return r;
  endfunction

  // Address decode of the gating copies and the translation word
  logic [NUM_MODES*NUM_GROUPS-1:0] wr_hit;
  logic [NUM_MODES*NUM_GROUPS-1:0] rd_hit;
  logic pll_rd_hit;

  always_comb
  begin
    wr_hit = '0;
    rd_hit = '0;
    for (int m = 0; m < NUM_MODES; m++)
    begin
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
        if (bus_req.addr == gate_offset(m, g))
        begin
          wr_hit[m * NUM_GROUPS + g] = bus_req.wr;
          rd_hit[m * NUM_GROUPS + g] = bus_req.rd;
        end
      end
    end
  end

  // Translation word has no write path
  assign pll_rd_hit = bus_req.rd && (bus_req.addr == OFS_PLL_TRANSLATION);

  // Gating registers, one word per mode and group
  logic [31:0] gate_reg [NUM_MODES][NUM_GROUPS];
  logic [31:0] gate_next [NUM_MODES][NUM_GROUPS];

  genvar gm;
  genvar gg;
  generate
    for (gm = 0; gm < NUM_MODES; gm++)
    begin : g_mode
      for (gg = 0; gg < NUM_GROUPS; gg++)
      begin : g_grp
        always_comb
        begin
          gate_next[gm][gg] = gate_reg[gm][gg];
          if (wr_hit[gm * NUM_GROUPS + gg])
          begin
            // Reserved bits keep their zero value
            gate_next[gm][gg] = bus_req.wdata & group_mask(gg);
          end
        end

        always_ff @(posedge clk or negedge resetn)
        begin
          if (!resetn)
          begin
            gate_reg[gm][gg] <= GATE_RESET;
          end
          else
          begin
            gate_reg[gm][gg] <= gate_next[gm][gg];
          end
        end
      end
    end
  endgenerate

  // PLL translation
  logic [PLL_W-1:0] pll_reg;
  logic [PLL_W-1:0] pll_next;
  logic [CRYSTAL_SELECTION_W-1:0] crystal_selection_prev_reg;
  logic [CRYSTAL_SELECTION_W-1:0] crystal_selection_prev_next;
  logic loaded_reg;
  logic loaded_next;
  logic crystal_selection_changed;

  assign crystal_selection_changed = (crystal_selection != crystal_selection_prev_reg);

  always_comb
  begin
    pll_next = pll_reg;
    crystal_selection_prev_next = crystal_selection;
    loaded_next = 1'b1;
    if (!loaded_reg || crystal_selection_changed)
    begin
      pll_next = PLL_TABLE[crystal_selection * PLL_W +: PLL_W];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_reg <= PLL_RESET;
      crystal_selection_prev_reg <= CRYSTAL_SELECTION_RESET;
      loaded_reg <= 1'b0;
    end
    else
    begin
      pll_reg <= pll_next;
      crystal_selection_prev_reg <= crystal_selection_prev_next;
      loaded_reg <= loaded_next;
    end
  end

  assign pll_output_divider_field = pll_reg[PLL_OD_LSB +: PLL_OD_W];
  assign pll_feedback = pll_reg[PLL_F_LSB +: PLL_F_W];
  assign pll_ref_divider = pll_reg[PLL_R_LSB +: PLL_R_W];

  // Power mode selection
  pcg_mode_t mode_reg;
  pcg_mode_t mode_next;

  always_comb
  begin
    mode_next = PCG_RUN;
    if (auto_clock_gating && deep_sleep_state)
    begin
      mode_next = PCG_DEEP;
    end
    else if (auto_clock_gating && sleep_state)
    begin
      mode_next = PCG_SLEEP;
    end
  end

  // Active gating set and unit enables
  pcg_gate_set_t active_set;
  logic [NUM_UNITS-1:0] en_reg;
  logic [NUM_UNITS-1:0] en_next;
  logic [RATE_W-1:0] rate_reg;
  logic [RATE_W-1:0] rate_next;
  logic [NUM_UNITS-1:0] fault_reg;
  logic [NUM_UNITS-1:0] fault_next;

  always_comb
  begin
    case (mode_reg)
      PCG_RUN: active_set = {gate_reg[0][2], gate_reg[0][1], gate_reg[0][0]};
      PCG_SLEEP: active_set = {gate_reg[1][2], gate_reg[1][1], gate_reg[1][0]};
      PCG_DEEP: active_set = {gate_reg[2][2], gate_reg[2][1], gate_reg[2][0]};
      default: active_set = {gate_reg[0][2], gate_reg[0][1], gate_reg[0][0]};
    endcase
  end

  always_comb
  begin
    en_next = '0;
    en_next[U_PWM] = active_set.group0[G0_PWM_BIT];
    en_next[U_ADC] = active_set.group0[G0_ADC_BIT];
    en_next[U_WDT] = active_set.group0[G0_WDT_BIT];
    en_next[U_COMPARATOR_ZERO_GATE] = active_set.group1[G1_COMPARATOR_ZERO_GATE_BIT];
    en_next[U_TIMER0] = active_set.group1[G1_TIMER0_BIT];
    en_next[U_TIMER1] = active_set.group1[G1_TIMER1_BIT];
    en_next[U_TIMER2] = active_set.group1[G1_TIMER2_BIT];
    en_next[U_SSI] = active_set.group1[G1_SSI_BIT];
    en_next[U_FIRST_ASYNC_SERIAL_GATE] = active_set.group1[G1_FIRST_ASYNC_SERIAL_GATE_BIT];
    en_next[U_SECOND_ASYNC_SERIAL_GATE] = active_set.group1[G1_SECOND_ASYNC_SERIAL_GATE_BIT];
    en_next[U_GPIO_A +: GPIO_PORTS] = active_set.group2[G2_GPIO_LSB +: GPIO_PORTS];
    rate_next = limit_rate(active_set.group0[G0_RATE_LSB +: RATE_W]);
    fault_next = unit_access & ~en_reg;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg <= PCG_RUN;
      en_reg <= '0;
      rate_reg <= RATE_125K;
      fault_reg <= '0;
    end
    else
    begin
      mode_reg <= mode_next;
      en_reg <= en_next;
      rate_reg <= rate_next;
      fault_reg <= fault_next;
    end
  end

  // Enables retimed on the low phase so the gate never cuts a pulse
  logic [NUM_UNITS-1:0] en_low_reg;

  always_ff @(negedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_low_reg <= '0;
    end
    else
    begin
      en_low_reg <= en_reg;
    end
  end

  assign unit_gclk = {NUM_UNITS{clk}} & en_low_reg;
  assign unit_clk_en = en_reg;
  assign unit_bus_fault = fault_reg;
  assign converter_max_sample_rate = rate_reg;

  // Read port, data one cycle after the strobe
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  always_comb
  begin
    rdata_next = '0;
    if (bus_req.rd)
    begin
      if (pll_rd_hit)
      begin
        rdata_next = {{(DATA_W-PLL_W){1'b0}}, pll_reg};
      end
      for (int m = 0; m < NUM_MODES; m++)
      begin
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
          if (rd_hit[m * NUM_GROUPS + g])
          begin
            rdata_next = gate_reg[m][g];
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= '0;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule // pcg_top
`default_nettype wire
